// >>> hw/elc_lamp_ctrl.sv
// exterior lamp controller: tail, head, fog, running light, follow-me-home, flasher
// assumes switch pins are asynchronous, link requests and adc readings are on ref_clk
//
// Overview of operation
// - tail relay on while tail switch on and no auto-cut; auto-cut state kept in storage
// - without smart key, cut tail when key out and driver door open, any order
// - tail switch on again or key in cancels auto-cut, tail back on; tail switch on re-cuts at once while the cut condition holds
// - smart key, no limp-home: cut when accessory, ignitions off and door open
// - low beam relay on with run ignition and low beam request
// - primary and run ignition with link failure forces low beam on
// - run ignition, high request and low beam active drive high relay and indicator
// - run ignition and passing request drive high relay, indicator and low beam
// - auto switch sets tail and low from sensor; primary ignition alone sets tail
// - power and watch sensor supply; outside 4 V to 6 V is a fault forcing low beam with primary ignition
// - supply fault needs 300 ms to raise and 300 ms to clear
// - export setting switches low beam with the tail under auto light
// - tail on below 1.77 V, off above 3.47 V sensor level
// - low beam on below 0.61 V, off above 1.00 V sensor level
// - fog relay on with fog switch, run ignition, low beam on, high beam off
// - running light released by low beam, high beam or passing, or parking brake
// - north american setting keeps tail on whenever low beam is on
// - ignition off, headlight request, door open then closed keeps lamps lit 30 s
// - count two lock commands as trigger; driver door opening clears the count
// - while active, door reopening restarts 20 min, closing restarts 30 s
// - each turn input transition starts a 2 kHz half-duty buzzer tone
// - run ignition flashes selected turn lamps at 85 per minute
// - hazard flashing takes precedence over turn signal
// - lamp failure during turn signal raises rate to 140 per minute
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module elc_lamp_ctrl
    import elc_pkg::*;
#(
    parameter int TICK_CYCLES = ELC_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ELC_SW_N-1:0] switch_pins,
    input wire elc_link_t link_req,
    input wire logic lock_cmd,
    input wire logic turn_lamp_fail,
    input wire logic [12:0] light_level_mv,
    input wire logic [12:0] supply_level_mv,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic tail_relay_out,
    output logic low_beam_relay_out,
    output logic high_beam_relay_out,
    output logic high_beam_indicator_out,
    output logic fog_relay_out,
    output logic running_light_out,
    output logic sensor_supply_en_out,
    output logic sensor_fault_out,
    output logic turn_left_out,
    output logic turn_right_out,
    output logic buzzer_out
);

    typedef struct packed {
        logic [ELC_SW_N-1:0] sw_s1;
        logic [ELC_SW_N-1:0] sw_s2;
        logic [ELC_SW_N-1:0] sw_smp;
        logic [ELC_SW_N-1:0] sw_deb;
        logic [ELC_SW_N-1:0] sw_prev;
        logic [13:0] tick_cnt;
        logic tick;
        logic [3:0] deb_cnt;
        logic [3:0] config_bits;
        logic autocut;
        logic cut_cond;
        logic tail_dark;
        logic head_dark;
        logic fault;
        logic [8:0] fault_cnt;
        logic [8:0] flash_cnt;
        logic flash_on;
        logic fail_latched;
        logic [11:0] buzz_div;
        logic [4:0] buzz_ms;
        logic buzz;
        logic [1:0] lock_cnt;
        elc_fmh_t fmh;
        logic [20:0] fmh_cnt;
        logic tail;
        logic low;
        logic high;
        logic fog;
        logic run_light;
        logic left;
        logic right;
        logic [7:0] rdata;
        logic supply_en;
    } elc_state_t;

    elc_state_t st_r;
    elc_state_t st_nxt;

    // hysteresis: turn on below the low mark, off above the high mark
    function automatic logic hyst(input logic cur, input logic [12:0] lvl,
                                  input logic [12:0] on_mv, input logic [12:0] off_mv);
        logic res;
        res = cur;
        if (lvl < on_mv) begin
            res = 1'b1;
        end else if (lvl > off_mv) begin
            res = 1'b0;
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic [ELC_SW_N-1:0] sw;
        logic primary_ignition;
        logic run_ignition;
        logic acc;
        logic door;
        logic door_open_edge;
        logic door_close_edge;
        logic smart;
        logic cut_now;
        logic oor;
        logic auto_tail;
        logic auto_low;
        logic fmh_lit;
        logic low_v;
        logic high_v;
        logic flash_req;
        logic haz;
        logic left_req;
        logic right_req;
        logic [8:0] half;
        sw = st_r.sw_deb;
        primary_ignition = sw[SW_PRIMARY_IGNITION];
        run_ignition = sw[SW_RUN_IGNITION];
        acc = sw[SW_ACC];
        door = sw[SW_DOOR];
        door_open_edge = door & ~st_r.sw_prev[SW_DOOR];
        door_close_edge = ~door & st_r.sw_prev[SW_DOOR];
        smart = st_r.config_bits[ELC_CFG_SMART_KEY] & ~link_req.limp_home;
        st_nxt = st_r;

        // sync and tick
        // two flops before anything reads the pins; the first one feeds only the second
        st_nxt.sw_s1 = switch_pins;
        st_nxt.sw_s2 = st_r.sw_s1;
        st_nxt.sw_prev = st_r.sw_deb;
        st_nxt.tick = 1'b0;
        if (st_r.tick_cnt == 14'(TICK_CYCLES - 1)) begin
            st_nxt.tick_cnt = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 14'h1;
        end

        // debounce
        // a level is accepted once two samples a debounce period apart agree
        if (st_r.tick) begin
            if (st_r.deb_cnt == ELC_DEB_TICKS - 4'h1) begin
                st_nxt.deb_cnt = '0;
                st_nxt.sw_smp = st_r.sw_s2;
                st_nxt.sw_deb = (st_r.sw_s2 & st_r.sw_smp) | (st_r.sw_deb & (st_r.sw_s2 | st_r.sw_smp));
            end else begin
                st_nxt.deb_cnt = st_r.deb_cnt + 4'h1;
            end
        end

        st_nxt.supply_en = primary_ignition | acc;
        oor = (supply_level_mv < ELC_SUPPLY_MIN_MV) || (supply_level_mv > ELC_SUPPLY_MAX_MV);
        if (!(primary_ignition || acc)) begin
            // unpowered sensor: nothing to judge, filter starts fresh
            st_nxt.fault = 1'b0;
            st_nxt.fault_cnt = '0;
        end else if (oor == st_r.fault) begin
            st_nxt.fault_cnt = '0;
        end else if (st_r.tick) begin
            if (st_r.fault_cnt == ELC_FAULT_TICKS - 9'h1) begin
                st_nxt.fault = oor;
                st_nxt.fault_cnt = '0;
            end else begin
                st_nxt.fault_cnt = st_r.fault_cnt + 9'h1;
            end
        end

        // tail and head hysteresis
        // a faulty supply makes the level meaningless, so the decision is frozen
        if (!st_r.fault) begin
            st_nxt.tail_dark = hyst(st_r.tail_dark, light_level_mv, ELC_TAIL_ON_MV, ELC_TAIL_OFF_MV);
            st_nxt.head_dark = hyst(st_r.head_dark, light_level_mv, ELC_HEAD_ON_MV, ELC_HEAD_OFF_MV);
        end

        auto_tail = link_req.auto_req & primary_ignition & st_r.tail_dark;
        auto_low = link_req.auto_req & primary_ignition & run_ignition &
                   (st_r.config_bits[ELC_CFG_EXPORT] ? st_r.tail_dark : st_r.head_dark);

        if (door_open_edge) begin
            st_nxt.lock_cnt = '0;
        end else if (lock_cmd && st_r.lock_cnt != 2'h2) begin
            st_nxt.lock_cnt = st_r.lock_cnt + 2'h1;
        end

        if (st_r.tick && st_r.fmh_cnt != '0) begin
            st_nxt.fmh_cnt = st_r.fmh_cnt - 21'h1;
        end
        if (primary_ignition || run_ignition) begin
            st_nxt.fmh = FMH_IDLE;
        end else begin
            unique case (st_r.fmh)
                FMH_IDLE: begin
                    if (link_req.low_req || st_r.lock_cnt == 2'h2) begin
                        st_nxt.fmh = FMH_ARMED;
                    end
                end
                FMH_ARMED: begin
                    if (door_open_edge) begin
                        st_nxt.fmh = FMH_OPENED;
                    end
                end
                FMH_OPENED: begin
                    if (door_close_edge) begin
                        st_nxt.fmh = FMH_HOLD;
                        st_nxt.fmh_cnt = ELC_HOLD_TICKS;
                    end
                end
                FMH_HOLD: begin
                    if (door_open_edge) begin
                        st_nxt.fmh = FMH_REOPEN;
                        st_nxt.fmh_cnt = ELC_REOPEN_TICKS;
                    end else if (st_r.fmh_cnt == '0) begin
                        st_nxt.fmh = FMH_IDLE;
                    end
                end
                FMH_REOPEN: begin
                    if (door_close_edge) begin
                        st_nxt.fmh = FMH_HOLD;
                        st_nxt.fmh_cnt = ELC_HOLD_TICKS;
                    end else if (st_r.fmh_cnt == '0) begin
                        st_nxt.fmh = FMH_IDLE;
                    end
                end
            endcase
        end
        fmh_lit = (st_r.fmh == FMH_HOLD) || (st_r.fmh == FMH_REOPEN);

        low_v = (run_ignition & link_req.low_req) |
                (primary_ignition & run_ignition & link_req.comm_fail) |
                (run_ignition & link_req.pass_req) |
                (primary_ignition & st_r.fault) |
                auto_low | fmh_lit;
        high_v = run_ignition & ((link_req.high_req & low_v) | link_req.pass_req);
        st_nxt.low = low_v;
        st_nxt.high = high_v;
        st_nxt.fog = sw[SW_FOG] & run_ignition & low_v & ~high_v;
        st_nxt.run_light = st_r.config_bits[ELC_CFG_RUN_LIGHT] & run_ignition &
                           ~(low_v | high_v | link_req.pass_req | sw[SW_PARK]);

        // tail auto-cut, smart key or key switch
        // acting on the rising edge of the combined level makes the order of events irrelevant
        cut_now = sw[SW_TAIL] & door & (smart ? ~(acc | primary_ignition | run_ignition) : ~sw[SW_KEY]);
        st_nxt.cut_cond = cut_now;
        if ((sw[SW_TAIL] & ~st_r.sw_prev[SW_TAIL]) || (sw[SW_KEY] & ~st_r.sw_prev[SW_KEY])) begin
            st_nxt.autocut = 1'b0;
        end
        if (reg_wr && reg_addr == ELC_REG_AUTOCUT) begin
            st_nxt.autocut = reg_wdata[0];
        end
        if (cut_now && !st_r.cut_cond) begin
            st_nxt.autocut = 1'b1;
        end
        st_nxt.tail = (sw[SW_TAIL] & ~st_r.autocut) | auto_tail | fmh_lit |
                      (st_r.config_bits[ELC_CFG_NORTH_AM] & low_v);

        haz = sw[SW_HAZ];
        left_req = haz | (run_ignition & sw[SW_LEFT] & (sw[SW_FULL] | ~sw[SW_RIGHT]));
        right_req = haz | (run_ignition & sw[SW_RIGHT] & (sw[SW_FULL] | ~sw[SW_LEFT]));
        flash_req = left_req | right_req;
        st_nxt.fail_latched = flash_req & (st_r.fail_latched | turn_lamp_fail);
        half = (st_r.fail_latched && !haz) ? ELC_FAST_HALF : ELC_FLASH_HALF;
        if (!flash_req) begin
            // first half-period starts lit as soon as a request appears
            st_nxt.flash_on = 1'b1;
            st_nxt.flash_cnt = '0;
        end else if (st_r.tick) begin
            if (st_r.flash_cnt >= half - 9'h1) begin
                st_nxt.flash_cnt = '0;
                st_nxt.flash_on = ~st_r.flash_on;
            end else begin
                st_nxt.flash_cnt = st_r.flash_cnt + 9'h1;
            end
        end
        st_nxt.left = left_req & st_r.flash_on;
        st_nxt.right = right_req & st_r.flash_on;

        if ((sw[SW_LEFT] ^ st_r.sw_prev[SW_LEFT]) || (sw[SW_RIGHT] ^ st_r.sw_prev[SW_RIGHT])) begin
            st_nxt.buzz_ms = ELC_BUZZ_TICKS;
        end else if (st_r.tick && st_r.buzz_ms != '0) begin
            st_nxt.buzz_ms = st_r.buzz_ms - 5'h1;
        end
        if (st_r.buzz_ms == '0) begin
            st_nxt.buzz = 1'b0;
            st_nxt.buzz_div = ELC_BUZZ_HALF_CYC - 12'h1; // burst opens high
        end else if (st_r.buzz_div == ELC_BUZZ_HALF_CYC - 12'h1) begin
            st_nxt.buzz_div = '0;
            st_nxt.buzz = ~st_r.buzz;
        end else begin
            st_nxt.buzz_div = st_r.buzz_div + 12'h1;
        end

        // register port: read data only in the cycle after the strobe
        if (reg_wr && reg_addr == ELC_REG_CONFIG) begin
            st_nxt.config_bits = reg_wdata[3:0];
        end
        st_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ELC_REG_CONFIG: st_nxt.rdata = {4'h0, st_r.config_bits};
                ELC_REG_STATUS: st_nxt.rdata = {st_r.fmh != FMH_IDLE, st_r.fault, st_r.fog,
                                                st_r.high, st_r.low, st_r.tail, st_r.head_dark, st_r.tail_dark};
                ELC_REG_AUTOCUT: st_nxt.rdata = {7'h00, st_r.autocut};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.config_bits <= ELC_CFG_RESET;
            st_r.fmh <= FMH_IDLE;
            st_r.flash_on <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    assign reg_rdata = st_r.rdata;
    assign tail_relay_out = st_r.tail;
    assign low_beam_relay_out = st_r.low;
    assign high_beam_relay_out = st_r.high;
    assign high_beam_indicator_out = st_r.high;
    assign fog_relay_out = st_r.fog;
    assign running_light_out = st_r.run_light;
    assign sensor_supply_en_out = st_r.supply_en; // supply follows accessory or primary ignition
    assign sensor_fault_out = st_r.fault;
    assign turn_left_out = st_r.left;
    assign turn_right_out = st_r.right;
    assign buzzer_out = st_r.buzz;

endmodule

// >>> hw/elc_pkg.sv
// constants and carrier types for the exterior lamp controller
// assumes a 10 MHz system clock and millivolt readings from an on-chip adc
package elc_pkg;

    // clock and time base
    localparam int ELC_CLK_HZ = 10_000_000;
    localparam int ELC_TICK_US = 1000;
    localparam int ELC_TICK_CYC = ELC_CLK_HZ / 1_000_000 * ELC_TICK_US;
    localparam int ELC_BUZZ_HZ = 2000;
    localparam logic [11:0] ELC_BUZZ_HALF_CYC = 12'(ELC_CLK_HZ / (2 * ELC_BUZZ_HZ));

    // times in milliseconds, seconds and minutes, counted in ticks
    localparam int ELC_DEB_MS = 10;
    localparam int ELC_FAULT_MS = 300;
    localparam int ELC_BUZZ_MS = 20;
    localparam int ELC_HOLD_S = 30;
    localparam int ELC_REOPEN_MIN = 20;
    localparam int ELC_FLASH_PPM = 85;
    localparam int ELC_FAST_PPM = 140;
    localparam logic [3:0] ELC_DEB_TICKS = 4'(ELC_DEB_MS * 1000 / ELC_TICK_US);
    localparam logic [8:0] ELC_FAULT_TICKS = 9'(ELC_FAULT_MS * 1000 / ELC_TICK_US);
    localparam logic [4:0] ELC_BUZZ_TICKS = 5'(ELC_BUZZ_MS * 1000 / ELC_TICK_US);
    localparam logic [20:0] ELC_HOLD_TICKS = 21'(ELC_HOLD_S * 1_000_000 / ELC_TICK_US);
    localparam logic [20:0] ELC_REOPEN_TICKS = 21'(ELC_REOPEN_MIN * 60_000_000 / ELC_TICK_US);
    localparam logic [8:0] ELC_FLASH_HALF = 9'(60_000_000 / (2 * ELC_FLASH_PPM) / ELC_TICK_US);
    localparam logic [8:0] ELC_FAST_HALF = 9'(60_000_000 / (2 * ELC_FAST_PPM) / ELC_TICK_US);

    // thresholds in millivolts
    localparam logic [12:0] ELC_SUPPLY_MIN_MV = 13'd4000;
    localparam logic [12:0] ELC_SUPPLY_MAX_MV = 13'd6000;
    localparam logic [12:0] ELC_TAIL_ON_MV = 13'd1770;
    localparam logic [12:0] ELC_TAIL_OFF_MV = 13'd3470;
    localparam logic [12:0] ELC_HEAD_ON_MV = 13'd610;
    localparam logic [12:0] ELC_HEAD_OFF_MV = 13'd1000;

    // register map, byte addresses
    localparam logic [3:0] ELC_REG_CONFIG = 4'h0;
    localparam logic [3:0] ELC_REG_STATUS = 4'h4;
    localparam logic [3:0] ELC_REG_AUTOCUT = 4'h8;
    localparam logic [3:0] ELC_CFG_RESET = 4'h0;
    localparam int ELC_CFG_SMART_KEY = 0;
    localparam int ELC_CFG_EXPORT = 1;
    localparam int ELC_CFG_NORTH_AM = 2;
    localparam int ELC_CFG_RUN_LIGHT = 3;

    // switch vector bit positions
    localparam int ELC_SW_N = 12;
    localparam int SW_TAIL = 0;
    localparam int SW_KEY = 1;
    localparam int SW_DOOR = 2;
    localparam int SW_ACC = 3;
    localparam int SW_PRIMARY_IGNITION = 4;
    localparam int SW_RUN_IGNITION = 5;
    localparam int SW_PARK = 6;
    localparam int SW_FOG = 7;
    localparam int SW_HAZ = 8;
    localparam int SW_LEFT = 9;
    localparam int SW_RIGHT = 10;
    localparam int SW_FULL = 11;

    // requests decoded by the switch module link
    typedef struct packed {
        logic low_req;
        logic high_req;
        logic pass_req;
        logic auto_req;
        logic comm_fail;
        logic limp_home;
    } elc_link_t;

    // follow-me-home sequence
    typedef enum logic [2:0] {FMH_IDLE, FMH_ARMED, FMH_OPENED, FMH_HOLD, FMH_REOPEN} elc_fmh_t;

endpackage

// >>> sim/elc_far_model.sv
// switch module link and light sensor seen from the controller's pins
// assumes the bench sets requests and sensor levels on ref_clk
`timescale 1ns/100ps
module elc_far_model
    import elc_pkg::*;
(
    input wire logic ref_clk,
    input wire elc_link_t cmd,
    input wire logic [12:0] light_mv,
    input wire logic [12:0] supply_mv,
    input wire logic supply_en,
    output elc_link_t link_req,
    output logic [12:0] light_level_mv,
    output logic [12:0] supply_level_mv
);
    // unpowered sensor reads zero, no stale level is left behind
    always_ff @(posedge ref_clk) begin
        link_req <= cmd;
        light_level_mv <= supply_en ? light_mv : 13'h0000;
        supply_level_mv <= supply_en ? supply_mv : 13'h0000;
    end
endmodule

// >>> sim/elc_lamp_monitor.sv
// port checker for the lamp controller
// assumes one clock and synchronous active low reset
`timescale 1ns/100ps
module elc_lamp_monitor
    import elc_pkg::*;
#(
    parameter int TICK_CYCLES = ELC_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [12:0] supply_level_mv,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic tail_relay_out,
    input wire logic low_beam_relay_out,
    input wire logic high_beam_relay_out,
    input wire logic high_beam_indicator_out,
    input wire logic sensor_supply_en_out,
    input wire logic sensor_fault_out,
    input wire logic turn_left_out,
    input wire logic buzzer_out
);
    localparam int FLT_MIN = (int'(ELC_FAULT_TICKS) - 1) * TICK_CYCLES;
    localparam int LIT_MAX = (int'(ELC_FLASH_HALF) + 1) * TICK_CYCLES;
    int oor_cnt;
    int inr_cnt;
    int lit_cnt;
    int buz_cnt;
    logic oor;
    assign oor = supply_level_mv < ELC_SUPPLY_MIN_MV || supply_level_mv > ELC_SUPPLY_MAX_MV;
    // run lengths of supply state, lit lamp and buzzer level
    always_ff @(posedge ref_clk) begin
        oor_cnt <= oor ? oor_cnt + 1 : 0;
        inr_cnt <= oor ? 0 : inr_cnt + 1;
        lit_cnt <= turn_left_out ? lit_cnt + 1 : 0;
        buz_cnt <= buzzer_out ? buz_cnt + 1 : 0;
    end
    sequence read_done;
        $past(reg_rd) ##0 1'b1;
    endsequence
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !tail_relay_out && !low_beam_relay_out
        && !buzzer_out && reg_rdata == 8'h00) else $error("outputs not clear after reset");
    chk_indicator_follows: assert property (high_beam_indicator_out == high_beam_relay_out)
        else $error("indicator differs from high relay");
    chk_high_needs_low: assert property (high_beam_relay_out |-> low_beam_relay_out || $past(low_beam_relay_out))
        else $error("high beam without low beam");
    chk_fault_filter: assert property ($rose(sensor_fault_out) |-> oor_cnt >= FLT_MIN)
        else $error("fault raised too early");
    chk_fault_clears: assert property ($fell(sensor_fault_out) && sensor_supply_en_out |-> inr_cnt >= FLT_MIN)
        else $error("fault cleared too early");
    chk_fault_powered: assert property (sensor_fault_out |-> sensor_supply_en_out || $past(sensor_supply_en_out))
        else $error("fault while sensor unpowered");
    chk_flash_half: assert property ($fell(turn_left_out) |-> lit_cnt <= LIT_MAX)
        else $error("turn lamp lit too long");
    chk_buzz_half: assert property (buzzer_out |-> buz_cnt <= int'(ELC_BUZZ_HALF_CYC))
        else $error("buzzer half period too long");
    chk_idle_rdata: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_unmapped_zero: assert property (read_done ##0 ($past(reg_addr) inside {4'h1, 4'hC, 4'hF})
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    cover property (sensor_fault_out && low_beam_relay_out);
endmodule
bind elc_lamp_ctrl elc_lamp_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .supply_level_mv(supply_level_mv), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tail_relay_out(tail_relay_out), .low_beam_relay_out(low_beam_relay_out),
    .high_beam_relay_out(high_beam_relay_out), .high_beam_indicator_out(high_beam_indicator_out),
    .sensor_supply_en_out(sensor_supply_en_out), .sensor_fault_out(sensor_fault_out),
    .turn_left_out(turn_left_out), .buzzer_out(buzzer_out));

// >>> sim/testbench.sv
// self-checking bench for the lamp controller with far side model
// assumes a short tick of 10 clocks so ms counts stay small
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: output mismatch", $time); end end
module testbench;
    import elc_pkg::*;
    localparam int TC = 10;
    localparam int O_TAIL = 10, O_LOW = 9, O_HIGH = 8, O_IND = 7, O_FOG = 6, O_FLT = 3, O_TL = 2, O_TR = 1, O_BZ = 0;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic [ELC_SW_N-1:0] sw = '0;
    elc_link_t cmd = '0, link_req;
    logic [12:0] light = 13'h1388, supply = 13'h1388, light_level_mv, supply_level_mv;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    logic reg_wr = 1'b0, reg_rd = 1'b0, fail = 1'b0;
    logic [10:0] outs;
    logic [31:0] seed = 32'h2DE3;
    logic [1:0] ta;
    int mismatches = 0, check_count = 0;
    initial forever #50 ref_clk = ~ref_clk;
    elc_far_model far (.ref_clk(ref_clk), .cmd(cmd), .light_mv(light), .supply_mv(supply),
        .supply_en(outs[4]), .link_req(link_req), .light_level_mv(light_level_mv), .supply_level_mv(supply_level_mv));
    elc_lamp_ctrl #(.TICK_CYCLES(TC)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .switch_pins(sw), .link_req(link_req),
        .lock_cmd(1'b0), .turn_lamp_fail(fail), .light_level_mv(light_level_mv), .supply_level_mv(supply_level_mv),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tail_relay_out(outs[10]), .low_beam_relay_out(outs[9]), .high_beam_relay_out(outs[8]),
        .high_beam_indicator_out(outs[7]), .fog_relay_out(outs[6]), .running_light_out(outs[5]),
        .sensor_supply_en_out(outs[4]), .sensor_fault_out(outs[3]), .turn_left_out(outs[2]),
        .turn_right_out(outs[1]), .buzzer_out(outs[0]));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // auto light hysteresis: {tail, low} from level and previous state
    function automatic logic [1:0] auto_exp(input logic [12:0] mv, input logic [1:0] p);
        auto_exp[1] = mv < ELC_TAIL_ON_MV ? 1'b1 : (mv > ELC_TAIL_OFF_MV ? 1'b0 : p[1]);
        auto_exp[0] = mv < ELC_HEAD_ON_MV ? 1'b1 : (mv > ELC_HEAD_OFF_MV ? 1'b0 : p[0]);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude;
        if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // data stand in the cycle after the taking edge
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // bounded wait for one output level; a timeout ends the run
    task automatic wait_out(input int idx, input logic v, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge ref_clk);
            #1;
            if (outs[idx] === v) return;
        end
        mismatches++;
        $display("Error %0t: output wait timed out", $time);
        conclude();
    endtask
    initial begin
        tick(6);
        rst_n <= 1'b1;
        tick(1);
        // config round trip with random values, then unmapped place
        repeat (4) begin
            seed = lfsr(seed);
            wr_reg(ELC_REG_CONFIG, {4'h0, seed[3:0]});
            rd_reg(ELC_REG_CONFIG, d);
            `CHK(d, {4'h0, seed[3:0]})
        end
        wr_reg(4'hC, 8'hFF);
        rd_reg(4'hC, d);
        `CHK(d, 8'h00)
        wr_reg(ELC_REG_CONFIG, 8'h00);
        // tail on, auto-cut with key out and door open together, key back cancels
        sw[SW_TAIL] <= 1'b1;
        sw[SW_KEY] <= 1'b1;
        wait_out(O_TAIL, 1'b1, 1000);
        sw[SW_KEY] <= 1'b0;
        sw[SW_DOOR] <= 1'b1;
        wait_out(O_TAIL, 1'b0, 1000);
        rd_reg(ELC_REG_AUTOCUT, d);
        `CHK(d[0], 1'b1)
        sw[SW_KEY] <= 1'b1;
        wait_out(O_TAIL, 1'b1, 1000);
        sw <= '0;
        wait_out(O_TAIL, 1'b0, 1000);
        // head lamps over the link
        sw[SW_PRIMARY_IGNITION] <= 1'b1;
        sw[SW_RUN_IGNITION] <= 1'b1;
        cmd.low_req <= 1'b1;
        wait_out(O_LOW, 1'b1, 1000);
        sw[SW_RUN_IGNITION] <= 1'b0;
        wait_out(O_LOW, 1'b0, 1000);
        sw[SW_RUN_IGNITION] <= 1'b1;
        cmd.high_req <= 1'b1;
        sw[SW_FOG] <= 1'b1;
        wait_out(O_HIGH, 1'b1, 1000);
        tick(400);
        `CHK(outs[O_IND], 1'b1)
        `CHK(outs[O_FOG], 1'b0)
        cmd.high_req <= 1'b0;
        wait_out(O_FOG, 1'b1, 1000);
        cmd.low_req <= 1'b0;
        wait_out(O_FOG, 1'b0, 1000);
        cmd.pass_req <= 1'b1;
        wait_out(O_HIGH, 1'b1, 1000);
        `CHK(outs[O_LOW], 1'b1)
        cmd.pass_req <= 1'b0;
        cmd.comm_fail <= 1'b1;
        wait_out(O_HIGH, 1'b0, 1000);
        wait_out(O_LOW, 1'b1, 1000);
        cmd.comm_fail <= 1'b0;
        sw[SW_FOG] <= 1'b0;
        wait_out(O_LOW, 1'b0, 1000);
        // auto light through the hysteresis bands, random levels in each
        cmd.auto_req <= 1'b1;
        ta = 2'b00;
        for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            case (k)
                0: light <= 13'd300 + 13'(seed[7:0]);
                1: light <= 13'd1100 + 13'(seed[8:0]);
                2: light <= 13'd2000 + 13'(seed[9:0]);
                3: light <= 13'd3600 + 13'(seed[8:0]);
                default: light <= 13'd700 + 13'(seed[7:0]);
            endcase
            tick(600);
            ta = auto_exp(light, ta);
            `CHK(outs[O_TAIL], ta[1])
            `CHK(outs[O_LOW], ta[0])
        end
        // supply below range: filtered fault forces low beam
        supply <= 13'd3000;
        tick(int'(ELC_FAULT_TICKS) * TC - 400);
        `CHK(outs[O_FLT], 1'b0)
        wait_out(O_FLT, 1'b1, 1000);
        wait_out(O_LOW, 1'b1, 50);
        supply <= 13'd5000;
        tick(int'(ELC_FAULT_TICKS) * TC - 400);
        `CHK(outs[O_FLT], 1'b1)
        wait_out(O_FLT, 1'b0, 1000);
        // full turn left, then hazard on top
        cmd <= '0;
        wr_reg(ELC_REG_CONFIG, 8'h08);
        sw[SW_LEFT] <= 1'b1;
        sw[SW_FULL] <= 1'b1;
        wait_out(O_BZ, 1'b1, 1000);
        wait_out(O_TL, 1'b1, 1000);
        wait_out(O_TL, 1'b0, int'(ELC_FLASH_HALF) * TC + 100);
        `CHK(outs[O_TR], 1'b0)
        `CHK(outs[5], 1'b1)
        fail <= 1'b1;
        wait_out(O_TL, 1'b1, int'(ELC_FAST_HALF) * TC + 100);
        sw[SW_HAZ] <= 1'b1;
        wait_out(O_TR, 1'b1, 5000);
        wait_out(O_TR, 1'b0, 5000);
        `CHK(outs[O_TL], 1'b0)
        sw <= '0;
        tick(10);
        conclude();
    end
endmodule
